/* File: rtl/ctrl_pkg.sv */
// Package: constants and carriers for bridge limiting and peak-and-hold control
package ctrl_pkg;
	localparam int CLK_MHZ = 200;
	// Off times in nanoseconds, typical
	localparam int TOFF0_NS = 31000;
	localparam int TOFF1_NS = 48000;
	localparam int TOFF2_NS = 62500;
	localparam int TOFF3_NS = 125000;
	// Shared-strategy filter times in nanoseconds
	localparam int DIAG_SH0_NS = 11200;
	localparam int DIAG_SH1_NS = 28900;
	localparam int DIAG_SH2_NS = 40000;
	localparam int DIAG_SH3_NS = 51200;
	// Individual-strategy filter times in nanoseconds
	localparam int DIAG_IN0_NS = 25600;
	localparam int DIAG_IN1_NS = 61200;
	localparam int DIAG_IN2_NS = 105600;
	localparam int DIAG_IN3_NS = 150000;
	localparam int CW = 16;
	localparam logic [CW-1:0] TOFF0_CYC = CW'(TOFF0_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] TOFF1_CYC = CW'(TOFF1_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] TOFF2_CYC = CW'(TOFF2_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] TOFF3_CYC = CW'(TOFF3_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] SH0_CYC = CW'(DIAG_SH0_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] SH1_CYC = CW'(DIAG_SH1_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] SH2_CYC = CW'(DIAG_SH2_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] SH3_CYC = CW'(DIAG_SH3_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] IN0_CYC = CW'(DIAG_IN0_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] IN1_CYC = CW'(DIAG_IN1_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] IN2_CYC = CW'(DIAG_IN2_NS * CLK_MHZ / 1000);
	localparam logic [CW-1:0] IN3_CYC = CW'(DIAG_IN3_NS * CLK_MHZ / 1000);
	// Diagnostic codes
	localparam logic [2:0] CODE_OC_SWITCHING = 3'h0;
	localparam logic [2:0] CODE_OC_FULL_ON = 3'h1;
	localparam logic [2:0] CODE_NO_DIAG = 3'h7;
	// Per-bridge configuration
	typedef struct packed {
		logic shunt_sense;
		logic bridge_limit_enable;
		logic active_freewheel_select;
		logic [1:0] limit_off_time_select;
		logic per_channel_filter_select;
	} bridge_cfg_s;
	// Per-bridge gate requests (hs0, ls0, hs1, ls1 ordered as ch1..ch4)
	typedef struct packed {
		logic [3:0] gate_on;
	} bridge_gate_s;
	function automatic logic [CW-1:0] toff_cycles(input logic [1:0] sel);
		unique case (sel)
			2'h0: toff_cycles = TOFF0_CYC;
			2'h1: toff_cycles = TOFF1_CYC;
			2'h2: toff_cycles = TOFF2_CYC;
			default: toff_cycles = TOFF3_CYC;
		endcase
	endfunction : toff_cycles
	function automatic logic [CW-1:0] diag_cycles(input logic indiv, input logic [1:0] code);
		unique case (code)
			2'h0: diag_cycles = indiv ? IN0_CYC : SH0_CYC;
			2'h1: diag_cycles = indiv ? IN1_CYC : SH1_CYC;
			2'h2: diag_cycles = indiv ? IN2_CYC : SH2_CYC;
			default: diag_cycles = indiv ? IN3_CYC : SH3_CYC;
		endcase
	endfunction : diag_cycles
endpackage : ctrl_pkg

/* File: rtl/bridge_limiter.sv */
// One H-bridge current limiter: chop high sides, flag, escalate to tri-state
`timescale 1ns/1ps
module bridge_limiter (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Configuration
	input ctrl_pkg::bridge_cfg_s cfg,
	input wire logic [5:0] limit_threshold,
	input wire logic [ctrl_pkg::CW-1:0] oc_filter_cycles,
	input wire logic [ctrl_pkg::CW-1:0] fil_on_cycles,
	// Requested gates and comparators
	input ctrl_pkg::bridge_gate_s gate_req,
	input wire logic limit_cmp,
	input wire logic oc_cmp_ls,
	input wire logic flag_read,
	// Results
	output ctrl_pkg::bridge_gate_s gate_out,
	output logic limit_reached_flag,
	output logic bridge_tristate,
	output logic [5:0] threshold_used
);
	typedef enum logic [1:0] {NORMAL, FILTER, OFF_PHASE, RETRY_ON} lim_state_e;
	lim_state_e state;
	lim_state_e next_state;
	logic [ctrl_pkg::CW-1:0] cnt;
	logic [ctrl_pkg::CW-1:0] next_cnt;
	wire active = cfg.shunt_sense && cfg.bridge_limit_enable;
	wire hs_cut = active && (state == OFF_PHASE);
	wire [ctrl_pkg::CW-1:0] toff = ctrl_pkg::toff_cycles(cfg.limit_off_time_select);
	wire [ctrl_pkg::CW-1:0] retry_len = ctrl_pkg::CW'(fil_on_cycles + oc_filter_cycles);
	wire cnt_done = (cnt == '0);
	// threshold field forwarded to comparator DAC
	assign threshold_used = limit_threshold;
	// high sides off; low sides keep requested freewheel
	assign gate_out.gate_on = bridge_tristate ? 4'h0 :
		{gate_req.gate_on[3], gate_req.gate_on[2] & ~hs_cut, gate_req.gate_on[1], gate_req.gate_on[0] & ~hs_cut};
	always_comb begin
		next_state = state;
		next_cnt = cnt_done ? cnt : ctrl_pkg::CW'(cnt - 1'b1);
		// only with shunt sensing and enable set
		if (!active) begin
			next_state = NORMAL;
			next_cnt = '0;
		end else begin
			unique case (state)
				NORMAL: if (limit_cmp) begin
					next_state = FILTER;
					next_cnt = oc_filter_cycles;
				end
				// filter only, blanking time not applied
				FILTER: if (!limit_cmp) begin
					next_state = NORMAL;
				end else if (cnt_done) begin
					next_state = OFF_PHASE;
					next_cnt = toff;
				end
				// compare at end of off time
				OFF_PHASE: if (cnt_done) begin
					if (limit_cmp) begin
						next_state = RETRY_ON;
						next_cnt = retry_len;
					end else begin
						next_state = NORMAL;
					end
				end
				// on for fil_on plus oc filter, then off again
				RETRY_ON: if (cnt_done) begin
					next_state = OFF_PHASE;
					next_cnt = toff;
				end
			endcase
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= NORMAL;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end
	// first crossing sets flag; set wins over read clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			limit_reached_flag <= 1'b0;
		end else if (active && limit_cmp) begin
			limit_reached_flag <= 1'b1;
		end else if (flag_read) begin
			limit_reached_flag <= 1'b0;
		end
	end
	// low-side comparator always watched while limiting
	wire oc_watch = oc_cmp_ls && (active || gate_req.gate_on[3] || gate_req.gate_on[1]);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bridge_tristate <= 1'b0;
		end else if (oc_watch) begin
			bridge_tristate <= 1'b1;
		end else if (flag_read) begin
			bridge_tristate <= 1'b0;
		end
	end
endmodule : bridge_limiter

/* File: rtl/ph_pair_diag.sv */
// One peak-and-hold pair: drive selection and ON-state diagnostic latches
`timescale 1ns/1ps
module ph_pair_diag (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Configuration
	input wire logic pair_enable,
	input wire logic highside_fet_type,
	input wire logic [1:0] serial_drive_select,
	input wire logic [1:0] serial_drive,
	input wire logic [1:0] pin_drive,
	input wire logic [ctrl_pkg::CW-1:0] overcurrent_blank_time,
	// Comparators, index 0 high side, 1 low side
	input wire logic [1:0] oc_cmp,
	input wire logic diag_read,
	// Results
	output logic [1:0] drive_on,
	output logic hs_gate_level,
	output logic [2:0] hs_code,
	output logic [2:0] ls_code
);
	logic [ctrl_pkg::CW-1:0] blank [2];
	logic [1:0] prot_off;
	// each side from pin or serial bit
	wire [1:0] cmd = (serial_drive_select & serial_drive) | (~serial_drive_select & pin_drive);
	// arrangement applies as soon as enabled
	assign drive_on = pair_enable ? (cmd & ~prot_off) : 2'h0;
	assign hs_gate_level = highside_fet_type ? ~drive_on[0] : drive_on[0];
	wire both_on = &drive_on;
	wire [1:0] oc_hit = oc_cmp & drive_on;
	wire [1:0] in_blank = {blank[1] != '0, blank[0] != '0};
	// code by blanking timer state; simultaneous gives switching code
	wire [2:0] hs_new = (in_blank[0] || (&oc_hit)) ? ctrl_pkg::CODE_OC_SWITCHING : ctrl_pkg::CODE_OC_FULL_ON;
	wire [2:0] ls_new = (in_blank[1] || (&oc_hit)) ? ctrl_pkg::CODE_OC_SWITCHING : ctrl_pkg::CODE_OC_FULL_ON;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			blank[0] <= '0;
			blank[1] <= '0;
			prot_off <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!cmd[i] || !pair_enable) begin
					blank[i] <= overcurrent_blank_time;
					prot_off[i] <= 1'b0;
				end else begin
					if (blank[i] != '0) begin
						blank[i] <= ctrl_pkg::CW'(blank[i] - 1'b1);
					end
					if (oc_hit[i]) begin
						prot_off[i] <= 1'b1;
					end
				end
			end
		end
	end
	// per-channel latches, updated only with both on
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hs_code <= ctrl_pkg::CODE_NO_DIAG;
			ls_code <= ctrl_pkg::CODE_NO_DIAG;
		end else begin
			if (both_on && oc_hit[0]) begin
				hs_code <= hs_new;
			end else if (diag_read) begin
				hs_code <= ctrl_pkg::CODE_NO_DIAG;
			end
			if (both_on && oc_hit[1]) begin
				ls_code <= ls_new;
			end else if (diag_read) begin
				ls_code <= ctrl_pkg::CODE_NO_DIAG;
			end
		end
	end
endmodule : ph_pair_diag

/* File: rtl/channel_ctrl.sv */
// Top: two bridge limiters, OFF-state filter timing, two peak-and-hold pairs
`timescale 1ns/1ps
// Operation
// - Limiting only with shunt sensing and enable
// - Threshold from channel 3 or 7 field
// - Channel 3/7 comparator limits, not overcurrent
// - Over threshold past filter: freewheel off time
// - After off time, below threshold resumes normal
// - Else retry on, off; repeat or tristate
// - Blanking time ignored for limit detection
// - Limit flag set once, cleared on read
// - Two-bit off time select, four values
// - Shared or per-channel filter time selection
// - Shared codes: 11.2/28.9/40/51.2 us
// - Individual codes: 25.6/61.2/105.6/150 us
// - Two pairs: ch1/ch4 and ch2/ch3
// - Pair arrangement applied immediately on enable
// - Type bit picks N or P high side
// - Each channel from pin or serial bit
// - Diagnostics per channel as standalone
// - Latches update only when both on
// - Code 000 blanking, 001 after blanking
// - Simultaneous overcurrent latches switching code both
// - Latches reset by reset or read
// - Low-side comparator active while limiting
module channel_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bridge configuration and thresholds
	input ctrl_pkg::bridge_cfg_s bridge1_cfg,
	input ctrl_pkg::bridge_cfg_s bridge2_cfg,
	input wire logic [5:0] ch3_threshold_field,
	input wire logic [5:0] ch7_threshold_field,
	input wire logic [ctrl_pkg::CW-1:0] oc_filter_cycles,
	input wire logic [ctrl_pkg::CW-1:0] fil_on_cycles,
	// Bridge gate requests and comparators
	input ctrl_pkg::bridge_gate_s bridge1_req,
	input ctrl_pkg::bridge_gate_s bridge2_req,
	input wire logic [7:0] oc_cmp_pin,
	input wire logic limit_flag_read,
	// OFF-state filter codes per channel
	input wire logic [15:0] off_filter_time_code,
	input wire logic [7:0] channel_off_event,
	// Peak-and-hold configuration
	input wire logic pair1_enable,
	input wire logic pair2_enable,
	input wire logic [7:0] highside_fet_type,
	input wire logic [7:0] serial_drive_select,
	input wire logic [7:0] serial_drive,
	input wire logic [7:0] channel_drive_pin_n,
	input wire logic [ctrl_pkg::CW-1:0] overcurrent_blank_time,
	input wire logic diag_read,
	// Bridge results
	output ctrl_pkg::bridge_gate_s bridge1_gate,
	output ctrl_pkg::bridge_gate_s bridge2_gate,
	output logic [1:0] limit_reached_flag,
	output logic [1:0] bridge_tristate,
	output logic [5:0] bridge1_limit_threshold,
	output logic [5:0] bridge2_limit_threshold,
	// Filter expiry pulses
	output logic [7:0] off_filter_done,
	// Peak-and-hold results
	output logic [3:0] ph_drive_on,
	output logic [1:0] ph_hs_gate_level,
	output logic [11:0] ph_codes
);
	// Pin synchronisers
	logic [7:0] cmp_s1;
	logic [7:0] cmp_s2;
	logic [7:0] pin_s1;
	logic [7:0] pin_s2;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cmp_s1 <= 8'h00;
			cmp_s2 <= 8'h00;
			pin_s1 <= 8'hFF;
			pin_s2 <= 8'hFF;
		end else begin
			cmp_s1 <= oc_cmp_pin;
			cmp_s2 <= cmp_s1;
			pin_s1 <= channel_drive_pin_n;
			pin_s2 <= pin_s1;
		end
	end
	wire [7:0] pin_on = ~pin_s2;
	// channel 3/7 comparator feeds limiter; channel 3 also feeds pair 2 low side
	bridge_limiter u_bridge1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.cfg(bridge1_cfg),
		.limit_threshold(ch3_threshold_field),
		.oc_filter_cycles(oc_filter_cycles),
		.fil_on_cycles(fil_on_cycles),
		.gate_req(bridge1_req),
		.limit_cmp(cmp_s2[2]),
		.oc_cmp_ls(cmp_s2[3]),
		.flag_read(limit_flag_read),
		.gate_out(bridge1_gate),
		.limit_reached_flag(limit_reached_flag[0]),
		.bridge_tristate(bridge_tristate[0]),
		.threshold_used(bridge1_limit_threshold)
	);
	bridge_limiter u_bridge2 (
		.ref_clk(ref_clk),
		.rst(rst),
		.cfg(bridge2_cfg),
		.limit_threshold(ch7_threshold_field),
		.oc_filter_cycles(oc_filter_cycles),
		.fil_on_cycles(fil_on_cycles),
		.gate_req(bridge2_req),
		.limit_cmp(cmp_s2[6]),
		.oc_cmp_ls(cmp_s2[7]),
		.flag_read(limit_flag_read),
		.gate_out(bridge2_gate),
		.limit_reached_flag(limit_reached_flag[1]),
		.bridge_tristate(bridge_tristate[1]),
		.threshold_used(bridge2_limit_threshold)
	);
	// shared uses first channel code of the bridge
	function automatic logic [1:0] pick_code(input logic indiv, input logic [15:0] codes, input int ch);
		logic [2:0] first;
		first = (ch < 4) ? 3'h0 : 3'h4;
		pick_code = indiv ? codes[2*ch +: 2] : codes[2*first +: 2];
	endfunction : pick_code
	logic [ctrl_pkg::CW-1:0] diag_cnt [8];
	logic [7:0] diag_run;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				diag_cnt[i] <= '0;
			end
			diag_run <= 8'h00;
			off_filter_done <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				off_filter_done[i] <= 1'b0;
				if (channel_off_event[i]) begin
					diag_run[i] <= 1'b1;
					diag_cnt[i] <= ctrl_pkg::diag_cycles(
						(i < 4) ? bridge1_cfg.per_channel_filter_select : bridge2_cfg.per_channel_filter_select,
						pick_code((i < 4) ? bridge1_cfg.per_channel_filter_select
							: bridge2_cfg.per_channel_filter_select, off_filter_time_code, i));
				end else if (diag_run[i]) begin
					if (diag_cnt[i] <= ctrl_pkg::CW'(1)) begin
						diag_run[i] <= 1'b0;
						off_filter_done[i] <= 1'b1;
					end else begin
						diag_cnt[i] <= ctrl_pkg::CW'(diag_cnt[i] - 1'b1);
					end
				end
			end
		end
	end
	// pair 1 is ch1 high, ch4 low
	ph_pair_diag u_pair1 (
		.ref_clk(ref_clk),
		.rst(rst),
		.pair_enable(pair1_enable),
		.highside_fet_type(highside_fet_type[0]),
		.serial_drive_select({serial_drive_select[3], serial_drive_select[0]}),
		.serial_drive({serial_drive[3], serial_drive[0]}),
		.pin_drive({pin_on[3], pin_on[0]}),
		.overcurrent_blank_time(overcurrent_blank_time),
		.oc_cmp({cmp_s2[3], cmp_s2[0]}),
		.diag_read(diag_read),
		.drive_on(ph_drive_on[1:0]),
		.hs_gate_level(ph_hs_gate_level[0]),
		.hs_code(ph_codes[2:0]),
		.ls_code(ph_codes[5:3])
	);
	// pair 2 is ch2 high, ch3 low
	ph_pair_diag u_pair2 (
		.ref_clk(ref_clk),
		.rst(rst),
		.pair_enable(pair2_enable),
		.highside_fet_type(highside_fet_type[1]),
		.serial_drive_select({serial_drive_select[2], serial_drive_select[1]}),
		.serial_drive({serial_drive[2], serial_drive[1]}),
		.pin_drive({pin_on[2], pin_on[1]}),
		.overcurrent_blank_time(overcurrent_blank_time),
		.oc_cmp({cmp_s2[2], cmp_s2[1]}),
		.diag_read(diag_read),
		.drive_on(ph_drive_on[3:2]),
		.hs_gate_level(ph_hs_gate_level[1]),
		.hs_code(ph_codes[8:6]),
		.ls_code(ph_codes[11:9])
	);
endmodule : channel_ctrl

/* File: verif/fet_load_model.sv */
// External FET and load model: comparator pins from injected faults and gate states
`timescale 1ns/1ps
module fet_load_model (
	// Mode and injected faults
	input wire logic ph_mode,
	input wire logic [7:0] fault,
	// Gate states
	input wire logic [3:0] ph_drive_on,
	// Comparator pins
	output logic [7:0] oc_cmp_pin
);
	wire logic [7:0] ph_on = {4'h0, ph_drive_on[1], ph_drive_on[3], ph_drive_on[2], ph_drive_on[0]};
	// in peak-and-hold mode, no current through an off FET
	assign oc_cmp_pin = ph_mode ? (fault & ph_on) : fault;
endmodule : fet_load_model

/* File: verif/channel_ctrl_sva.sv */
// Port assertions for the channel control top
`timescale 1ns/1ps
module channel_ctrl_sva (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Bridge side
	input ctrl_pkg::bridge_cfg_s bridge1_cfg,
	input wire logic [5:0] ch3_threshold_field,
	input wire logic [5:0] ch7_threshold_field,
	input wire logic [5:0] bridge1_limit_threshold,
	input wire logic [5:0] bridge2_limit_threshold,
	input ctrl_pkg::bridge_gate_s bridge1_req,
	input ctrl_pkg::bridge_gate_s bridge1_gate,
	input wire logic [7:0] oc_cmp_pin,
	input wire logic limit_flag_read,
	input wire logic [1:0] limit_reached_flag,
	input wire logic [1:0] bridge_tristate,
	// Peak-and-hold side
	input wire logic pair1_enable,
	input wire logic [7:0] highside_fet_type,
	input wire logic [7:0] serial_drive_select,
	input wire logic [7:0] serial_drive,
	input wire logic diag_read,
	input wire logic [3:0] ph_drive_on,
	input wire logic [1:0] ph_hs_gate_level,
	input wire logic [11:0] ph_codes
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire logic lim1 = bridge1_cfg.shunt_sense & bridge1_cfg.bridge_limit_enable;
	property p_code_cause;
		$changed(ph_codes[5:0]) && !$past(diag_read) && !$past(rst)
			|-> ($past(ph_drive_on[1:0]) == 2'h3 || $past(ph_drive_on[1:0], 2) == 2'h3)
			&& (ph_codes[2:0] == $past(ph_codes[2:0]) || ph_codes[2:1] == 2'h0)
			&& (ph_codes[5:3] == $past(ph_codes[5:3]) || ph_codes[5:4] == 2'h0);
	endproperty
	// Protection is cleared while the command is low, so a fresh rise must drive
	property p_serial_on;
		pair1_enable && serial_drive_select[0] && $stable(serial_drive_select[0]) && $rose(serial_drive[0])
			|-> ph_drive_on[0];
	endproperty
	AST_THRESH1: assert property (bridge1_limit_threshold == ch3_threshold_field)
		else $error("bridge 1 threshold not from channel 3 field");
	AST_THRESH2: assert property (bridge2_limit_threshold == ch7_threshold_field)
		else $error("bridge 2 threshold not from channel 7 field");
	AST_NO_LIMIT: assert property ((!lim1)[*4] |-> !$rose(limit_reached_flag[0]))
		else $error("limit flag set while limiting is off");
	AST_FLAG_SET: assert property ((lim1 && oc_cmp_pin[2] && !limit_flag_read)[*6] |-> limit_reached_flag[0])
		else $error("limit flag missing");
	AST_FLAG_CLEAR: assert property ((!oc_cmp_pin[2])[*4] ##0 limit_flag_read |=> !limit_reached_flag[0])
		else $error("limit flag not cleared by read");
	AST_HS_REQ: assert property ((bridge1_gate.gate_on & ~bridge1_req.gate_on & 4'h5) == 4'h0)
		else $error("high side on without request");
	AST_TRI_OFF: assert property (bridge_tristate[0] |-> bridge1_gate.gate_on == 4'h0)
		else $error("gate on while bridge floats");
	AST_CODE_CAUSE: assert property (p_code_cause)
		else $error("pair code changed without both channels on");
	AST_FET_LEVEL: assert property (ph_hs_gate_level[0] == (ph_drive_on[0] ^ highside_fet_type[0]))
		else $error("high side level ignores transistor type");
	AST_SERIAL: assert property (pair1_enable && serial_drive_select[0] && !serial_drive[0] |-> !ph_drive_on[0])
		else $error("serial drive off not followed");
	AST_SERIAL_ON: assert property (p_serial_on)
		else $error("serial drive on not followed");
	cover property (lim1 && $rose(limit_reached_flag[0]));
	cover property ($rose(bridge_tristate[0]));
	cover property (ph_codes[5:0] == 6'h00);
endmodule : channel_ctrl_sva

/* File: verif/channel_ctrl_tb.sv */
// Self-checking bench for limiting, filter timing and peak-and-hold
`timescale 1ns/1ps
module channel_ctrl_tb;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	ctrl_pkg::bridge_cfg_s bridge1_cfg = '0;
	ctrl_pkg::bridge_cfg_s bridge2_cfg = '0;
	ctrl_pkg::bridge_gate_s bridge1_req = '0;
	ctrl_pkg::bridge_gate_s bridge2_req = '0;
	ctrl_pkg::bridge_gate_s bridge1_gate, bridge2_gate;
	logic [5:0] ch3_threshold_field = '0, ch7_threshold_field = '0, bridge1_limit_threshold, bridge2_limit_threshold;
	logic [15:0] oc_filter_cycles = 16'h4, fil_on_cycles = 16'h4, overcurrent_blank_time = 16'h28;
	logic [15:0] off_filter_time_code = '0;
	logic limit_flag_read = 1'h0, diag_read = 1'h0, pair1_enable = 1'h0, pair2_enable = 1'h0, ph_mode = 1'h0;
	logic [7:0] fault = '0, channel_off_event = '0, highside_fet_type = '0, serial_drive_select = '0;
	logic [7:0] serial_drive = '0, channel_drive_pin_n = 8'hFF, oc_cmp_pin, off_filter_done, d;
	logic [1:0] limit_reached_flag, bridge_tristate, ph_hs_gate_level;
	logic [3:0] ph_drive_on;
	logic [11:0] ph_codes;
	int num_errors = 0;
	int check_count = 0;
	int n;
	int at [8];
	channel_ctrl i_dut (.ref_clk, .rst, .bridge1_cfg, .bridge2_cfg, .ch3_threshold_field, .ch7_threshold_field,
		.oc_filter_cycles, .fil_on_cycles, .bridge1_req, .bridge2_req, .oc_cmp_pin, .limit_flag_read,
		.off_filter_time_code, .channel_off_event, .pair1_enable, .pair2_enable, .highside_fet_type,
		.serial_drive_select, .serial_drive, .channel_drive_pin_n, .overcurrent_blank_time, .diag_read,
		.bridge1_gate, .bridge2_gate, .limit_reached_flag, .bridge_tristate, .bridge1_limit_threshold,
		.bridge2_limit_threshold, .off_filter_done, .ph_drive_on, .ph_hs_gate_level, .ph_codes);
	fet_load_model i_load (.ph_mode, .fault, .ph_drive_on, .oc_cmp_pin);
	always #2.5 ref_clk = ~ref_clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic check_near(input int m, input int e);
		check((m >= e - 4 && m <= e + 4) ? e : m, e);
	endtask : check_near
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc
	task automatic pulse(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask : pulse
	task automatic hs_wait(input logic on, input int lim, output int m);
		m = 0;
		while (((bridge1_gate.gate_on & 4'h5) != 4'h0) != on && m < lim) begin
			cyc(1);
			m++;
		end
	endtask : hs_wait
	function automatic int toff_exp(input logic [1:0] s);
		int t [4] = '{6200, 9600, 12500, 25000};
		return t[s];
	endfunction : toff_exp
	function automatic int diag_exp(input logic ind, input logic [1:0] c);
		int t [8] = '{2240, 5780, 8000, 10240, 5120, 12240, 21120, 30000};
		return t[{ind, c}];
	endfunction : diag_exp
	// Watchdog about 10000 cycles past the expected run length of some 90000
	initial begin
		cyc(100000);
		num_errors++;
		final_report();
	end
	initial begin
		n = $urandom(32'hFFED);
		cyc(12);
		rst = 1'h0;
		cyc(2);
		repeat (8) begin
			ch3_threshold_field = 6'($urandom);
			ch7_threshold_field = 6'($urandom);
			bridge2_req.gate_on = 4'($urandom);
			cyc(1);
			check(bridge1_limit_threshold, ch3_threshold_field);
			check(bridge2_limit_threshold, ch7_threshold_field);
			check(bridge2_gate, bridge2_req);
		end
		bridge1_req.gate_on = 4'h9;
		for (int i = 0; i < 2; i++) begin
			bridge1_cfg.shunt_sense = i[0];
			bridge1_cfg.bridge_limit_enable = !i[0];
			fault[2] = 1'h1;
			cyc(20);
			check({limit_reached_flag[0], bridge1_gate}, 5'h09);
			fault[2] = 1'h0;
			cyc(4);
		end
		bridge1_cfg.shunt_sense = 1'h1;
		bridge1_cfg.bridge_limit_enable = 1'h1;
		for (int s = 0; s < 4; s++) begin
			bridge1_cfg.limit_off_time_select = 2'(s);
			bridge1_cfg.active_freewheel_select = 1'($urandom);
			bridge1_req.gate_on = $urandom_range(1) ? 4'h9 : 4'h6;
			cyc(4);
			fault[2] = 1'h1;
			hs_wait(1'h0, 50, n);
			check(n >= 5 && n <= 12, 1'h1);
			check(limit_reached_flag[0], 1'h1);
			if (s != 0) fault[2] = 1'h0;
			hs_wait(1'h1, 30000, n);
			check_near(n, toff_exp(2'(s)));
			if (s == 0) begin
				hs_wait(1'h0, 50, n);
				check_near(n, 8);
				fault[2] = 1'h0;
				hs_wait(1'h1, 30000, n);
				check_near(n, toff_exp(2'h0));
			end
			cyc(60);
			check(bridge1_gate, bridge1_req);
			pulse(limit_flag_read);
			check(limit_reached_flag[0], 1'h0);
		end
		fault[3:2] = 2'h3;
		cyc(20);
		check({bridge_tristate[0], bridge1_gate}, 5'h10);
		fault = '0;
		cyc(4);
		pulse(limit_flag_read);
		check(bridge_tristate[0], 1'h0);
		bridge2_cfg.per_channel_filter_select = 1'h1;
		off_filter_time_code = {2'h3, 2'h2, 2'h1, 2'h0, 8'($urandom)};
		at = '{default: 0};
		channel_off_event = 8'hFF;
		cyc(1);
		channel_off_event = '0;
		for (int c = 0; c < 30100; c++) begin
			for (int i = 0; i < 8; i++) if (off_filter_done[i]) at[i] = c;
			cyc(1);
		end
		for (int i = 0; i < 8; i++)
			check_near(at[i], diag_exp(i >= 4, off_filter_time_code[(i < 4 ? 0 : 2 * i) +: 2]));
		ph_mode = 1'h1;
		pair1_enable = 1'h1;
		pair2_enable = 1'h1;
		repeat (8) begin
			highside_fet_type = 8'($urandom);
			serial_drive_select = 8'($urandom);
			serial_drive = 8'($urandom);
			channel_drive_pin_n = 8'($urandom);
			d = (serial_drive_select & serial_drive) | (~serial_drive_select & ~channel_drive_pin_n);
			cyc(4);
			check(ph_drive_on, {d[2], d[1], d[3], d[0]});
			check(ph_hs_gate_level, d[1:0] ^ highside_fet_type[1:0]);
		end
		serial_drive_select = 8'hFF;
		serial_drive = 8'h01;
		fault = 8'h01;
		cyc(20);
		check(ph_codes, 12'hFFF);
		fault = '0;
		serial_drive = '0;
		cyc(1);
		serial_drive = 8'h09;
		cyc(60);
		fault = 8'h01;
		cyc(10);
		check(ph_codes, 12'hFF9);
		fault = '0;
		serial_drive = '0;
		cyc(4);
		pulse(diag_read);
		check(ph_codes, 12'hFFF);
		serial_drive = 8'h09;
		fault = 8'h09;
		cyc(10);
		check(ph_codes, 12'hFC0);
		fault = '0;
		serial_drive = '0;
		rst = 1'h1;
		cyc(2);
		rst = 1'h0;
		cyc(3);
		check({limit_reached_flag, ph_codes}, 14'h0FFF);
		final_report();
	end
endmodule : channel_ctrl_tb
bind channel_ctrl channel_ctrl_sva i_sva (.ref_clk, .rst, .bridge1_cfg, .ch3_threshold_field, .ch7_threshold_field,
	.bridge1_limit_threshold, .bridge2_limit_threshold, .bridge1_req, .bridge1_gate, .oc_cmp_pin, .limit_flag_read,
	.limit_reached_flag, .bridge_tristate, .pair1_enable, .highside_fet_type, .serial_drive_select, .serial_drive,
	.diag_read, .ph_drive_on, .ph_hs_gate_level, .ph_codes);
